// File: line_mode_pkg.sv
// Shared types and constants for the line mode, coding and loss-of-signal block.
package line_mode_pkg;

    typedef enum logic [1:0] {
        STD_E1_DOUBLEFRAME = 2'b00,
        STD_T1             = 2'b01,
        STD_J1             = 2'b10
    } std_mode_t;

    typedef enum logic [1:0] {
        CODE_AMI      = 2'b00,
        CODE_HDB3     = 2'b01,
        CODE_CMI      = 2'b10,
        CODE_CMI_HDB3 = 2'b11
    } line_code_t;

    typedef struct packed {
        logic       compensation_disable;
        logic       ais_insert_disable;
        logic       receive_free_run;
        logic       transmit_transparent;
        logic       transmit_free_run;
        logic       framer_ais_send;
        logic       standard_select;
        logic       j1_select;
        logic       digital_interface;
        logic       rail_mode_select;
        logic       cmi_select;
        logic [1:0] transmit_code_select;
        logic [1:0] receive_code_select;
        logic [7:0] detection_pulse_count;
        logic [7:0] recovery_pulse_count;
    } cfg_t;

    typedef struct packed {
        logic transmit_soft_reset;
        logic receive_soft_reset;
    } cmd_t;

    localparam cfg_t       CFG_RESET      = cfg_t'(31'h0000_0000);
    localparam logic [1:0] CODE_SEL_HDB3  = 2'h3;
    localparam int         CLK_PERIOD_NS  = 20;
    localparam int         SETTLE_TIME_NS = 20000;
    localparam int         SETTLE_CYCLES  = SETTLE_TIME_NS / CLK_PERIOD_NS;
    localparam logic [8:0] FRAME_LEN_E1   = 9'h100;
    localparam logic [8:0] FRAME_LEN_T1   = 9'h0C1;
    localparam logic       FRAME_BIT      = 1'h1;
    localparam logic [3:0] LOS_STEP_SHIFT = 4'h4;

    // Analog lines cannot carry CMI, so CMI applies only on the digital side.
    function automatic line_code_t decode_code(input logic [1:0] sel,
                                               input logic       cmi,
                                               input logic       digital);
        logic hdb3;
        hdb3 = (sel == CODE_SEL_HDB3);
        if (digital && cmi) begin
            decode_code = hdb3 ? CODE_CMI_HDB3 : CODE_CMI;
        end else begin
            decode_code = hdb3 ? CODE_HDB3 : CODE_AMI;
        end
    endfunction

endpackage

// File: los_detect.sv
// Loss-of-signal detection and recovery by zero and one counting.
module los_detect
    import line_mode_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       clear_i,
    input  wire logic       valid_i,
    input  wire logic       bit_i,
    input  wire logic [7:0] pcd_i,
    input  wire logic [7:0] pcr_i,
    output logic            los_o,
    output logic            change_o
);

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    logic [12:0] zeros_ff;
    logic [12:0] win_ff;
    logic [8:0]  ones_ff;
    logic [12:0] thr;
    logic [8:0]  rec;

    assign thr = 13'({9'(pcd_i) + 9'h001, 4'h0});
    assign rec = 9'(pcr_i) + 9'h001;

    always_ff @(posedge clk_i) begin
        if (reset_i || clear_i) begin
            zeros_ff <= 13'h0000;
            win_ff   <= 13'h0000;
            ones_ff  <= 9'h000;
            los_o    <= 1'b0;
            change_o <= 1'b0;
        end else begin
            change_o <= 1'b0;
            if (valid_i && !los_o) begin
                if (bit_i) begin
                    zeros_ff <= 13'h0000;
                end else if (zeros_ff + 13'h0001 >= thr) begin
                    zeros_ff <= 13'h0000;
                    los_o    <= 1'b1;
                    change_o <= 1'b1;
                end else begin
                    zeros_ff <= zeros_ff + 13'h0001;
                end
            end else if (valid_i) begin
                // Ones only count inside one detection interval.
                if (ones_ff + 9'(bit_i) >= rec) begin
                    ones_ff  <= 9'h000;
                    win_ff   <= 13'h0000;
                    los_o    <= 1'b0;
                    change_o <= 1'b1;
                end else if (win_ff + 13'h0001 >= thr) begin
                    ones_ff <= 9'h000;
                    win_ff  <= 13'h0000;
                end else begin
                    ones_ff <= ones_ff + 9'(bit_i);
                    win_ff  <= win_ff + 13'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_los_on_zero:
        assert property ($rose(los_o) |->
            $past(valid_i) && !$past(bit_i)
            && $past(zeros_ff) + 13'h0001 == $past(thr))
        else $error("LOS rose without the zero count reaching threshold");

    a_los_off_ones:
        assert property ($fell(los_o) && !$past(clear_i) |->
            $past(ones_ff) + 9'($past(bit_i)) == $past(rec))
        else $error("LOS cleared without the one count reaching target");

    a_los_event:
        assert property (##1 (los_o != $past(los_o)) && !$past(clear_i)
            |-> change_o)
        else $error("LOS change not reported as an event");

endmodule

// File: line_mode_config_los.sv
// Line mode selection, coding selection, data path controls and LOS flag.
module line_mode_config_los
    import line_mode_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       cfg_wr_i,
    input  wire cfg_t       cfg_wdata_i,
    input  wire cmd_t       cmd_i,
    input  wire logic       tx_valid_i,
    input  wire logic       tx_data_i,
    input  wire logic       tx_frame_sync_i,
    input  wire logic       rx_valid_i,
    input  wire logic       rx_data_i,
    input  wire logic       rx_frame_sync_i,
    output cfg_t            cfg_rdata_o,
    output std_mode_t       std_mode_o,
    output logic            clock_settled_o,
    output line_code_t      tx_code_o,
    output line_code_t      rx_code_o,
    output logic            defined_mode_o,
    output logic            tx_valid_o,
    output logic            tx_data_o,
    output logic            rx_valid_o,
    output logic            rx_data_o,
    output logic            rx_slip_o,
    output logic            los_o,
    output logic            los_event_o
);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic       std_prev_ff;
    logic [9:0] settle_cnt_ff;
    logic [8:0] tx_pos_ff;
    logic [8:0] rx_pos_ff;
    logic [8:0] frame_len;
    logic       tx_at_sync;
    logic       los_clear;

    function automatic logic [8:0] next_pos(input logic [8:0] pos,
                                            input logic [8:0] len);
        next_pos = (pos == len - 9'h001) ? 9'h000 : pos + 9'h001;
    endfunction

    // Command bits act once and are not stored, so they never read back.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_rdata_o <= CFG_RESET;
        end else if (cfg_wr_i) begin
            cfg_rdata_o <= cfg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            defined_mode_o <= 1'b0;
        end else begin
            defined_mode_o <= cfg_rdata_o.compensation_disable;
        end
    end

    // ------------------------------------------------------------------
    // Standard selection and clock settling
    // ------------------------------------------------------------------
    // A change of standard_select restarts settling, a change of j1_select
    // alone does not; the mode follows only once the clock system has settled.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            std_prev_ff     <= 1'b0;
            settle_cnt_ff   <= 10'h000;
            clock_settled_o <= 1'b1;
            std_mode_o      <= STD_E1_DOUBLEFRAME;
        end else begin
            std_prev_ff <= cfg_rdata_o.standard_select;
            if (std_prev_ff != cfg_rdata_o.standard_select) begin
                settle_cnt_ff   <= 10'(SETTLE_CYCLES);
                clock_settled_o <= 1'b0;
            end else if (settle_cnt_ff > 10'h001) begin
                settle_cnt_ff <= settle_cnt_ff - 10'h001;
            end else if (settle_cnt_ff == 10'h001) begin
                settle_cnt_ff   <= 10'h000;
                clock_settled_o <= 1'b1;
            end
            // The edge that first sees a change must not let the new
            // standard through before settling has even begun.
            if (clock_settled_o && settle_cnt_ff == 10'h000
                && std_prev_ff == cfg_rdata_o.standard_select) begin
                if (!cfg_rdata_o.standard_select) begin
                    std_mode_o <= STD_E1_DOUBLEFRAME;
                end else if (cfg_rdata_o.j1_select) begin
                    std_mode_o <= STD_J1;
                end else begin
                    std_mode_o <= STD_T1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Line code selection
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_code_o <= CODE_AMI;
            rx_code_o <= CODE_AMI;
        end else begin
            tx_code_o <= decode_code(cfg_rdata_o.transmit_code_select,
                                     cfg_rdata_o.cmi_select,
                                     cfg_rdata_o.digital_interface);
            rx_code_o <= decode_code(cfg_rdata_o.receive_code_select,
                                     cfg_rdata_o.cmi_select,
                                     cfg_rdata_o.digital_interface);
        end
    end

    // ------------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------------
    assign frame_len  = (std_mode_o == STD_E1_DOUBLEFRAME) ? FRAME_LEN_E1
                                                         : FRAME_LEN_T1;
    assign tx_at_sync = tx_frame_sync_i
                        && !cfg_rdata_o.transmit_free_run;

    always_ff @(posedge clk_i) begin
        if (reset_i || cmd_i.transmit_soft_reset) begin
            tx_pos_ff  <= 9'h000;
            tx_valid_o <= 1'b0;
            tx_data_o  <= 1'b0;
        end else begin
            tx_valid_o <= tx_valid_i;
            if (tx_valid_i) begin
                tx_pos_ff <= tx_at_sync ? 9'h001
                                        : next_pos(tx_pos_ff, frame_len);
                if (cfg_rdata_o.transmit_transparent) begin
                    tx_data_o <= tx_data_i;
                end else if (tx_at_sync || tx_pos_ff == 9'h000) begin
                    tx_data_o <= FRAME_BIT;
                end else begin
                    tx_data_o <= tx_data_i;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i || cmd_i.receive_soft_reset) begin
            rx_pos_ff  <= 9'h000;
            rx_valid_o <= 1'b0;
            rx_data_o  <= 1'b0;
            rx_slip_o  <= 1'b0;
        end else begin
            rx_valid_o <= rx_valid_i;
            rx_slip_o  <= 1'b0;
            if (rx_valid_i) begin
                rx_pos_ff <= next_pos(rx_pos_ff, frame_len);
                // A slip is only flagged when the framer steers the store.
                rx_slip_o <= rx_frame_sync_i && rx_pos_ff != 9'h000
                             && !cfg_rdata_o.receive_free_run;
                if (cfg_rdata_o.framer_ais_send) begin
                    rx_data_o <= 1'b1;
                end else if (los_o && !cfg_rdata_o.ais_insert_disable) begin
                    rx_data_o <= 1'b1;
                end else begin
                    rx_data_o <= rx_data_i;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Loss of signal
    // ------------------------------------------------------------------
    assign los_clear = cmd_i.receive_soft_reset;

    los_detect u_los (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .clear_i  (los_clear),
        .valid_i  (rx_valid_i),
        .bit_i    (rx_data_i),
        .pcd_i    (cfg_rdata_o.detection_pulse_count),
        .pcr_i    (cfg_rdata_o.recovery_pulse_count),
        .los_o    (los_o),
        .change_o (los_event_o)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_reset_e1_mode:
        assert property ($past(reset_i) |->
            std_mode_o == STD_E1_DOUBLEFRAME && clock_settled_o)
        else $error("Mode after reset is not E1 doubleframe");

    // Cycles spent unsettled are counted here, since the settle time is
    // too long for a plain delay range.
    logic [10:0] settle_low_ff;

    always_ff @(posedge clk_i) begin
        if (reset_i || clock_settled_o
            || std_prev_ff != cfg_rdata_o.standard_select) begin
            settle_low_ff <= 11'h000;
        end else begin
            settle_low_ff <= settle_low_ff + 11'h001;
        end
    end

    a_settle_time:
        assert property ($changed(cfg_rdata_o.standard_select)
            |=> !clock_settled_o)
        else $error("Clock settling did not start on a standard change");

    a_settle_length:
        assert property ($rose(clock_settled_o) |->
            settle_low_ff == 11'(SETTLE_CYCLES))
        else $error("Clock settling did not last the settle time");

    a_settle_bound:
        assert property (settle_low_ff <= 11'(SETTLE_CYCLES))
        else $error("Clock settling overran the settle time");

    a_j1_needs_t1:
        assert property (std_mode_o == STD_J1 |->
            cfg_rdata_o.standard_select
            || $past(cfg_rdata_o.standard_select)
            || !clock_settled_o || $rose(clock_settled_o))
        else $error("J1 mode without T1/J1 standard selected");

    a_cfg_readback:
        assert property (cfg_wr_i |=> cfg_rdata_o == $past(cfg_wdata_i))
        else $error("Written configuration does not read back");

    a_analog_codes:
        assert property (!$past(cfg_rdata_o.digital_interface) |->
            tx_code_o inside {CODE_AMI, CODE_HDB3}
            && rx_code_o inside {CODE_AMI, CODE_HDB3})
        else $error("CMI code chosen on the analog interface");

    a_digital_cmi:
        assert property (cfg_rdata_o.digital_interface
            && cfg_rdata_o.cmi_select |=>
            tx_code_o == (($past(cfg_rdata_o.transmit_code_select)
                == CODE_SEL_HDB3) ? CODE_CMI_HDB3 : CODE_CMI))
        else $error("CMI not selected on the digital interface");

    a_ais_blocked:
        assert property (rx_valid_i && cfg_rdata_o.ais_insert_disable
            && !cfg_rdata_o.framer_ais_send && !cmd_i.receive_soft_reset
            |=> rx_data_o == $past(rx_data_i))
        else $error("AIS inserted while insertion is disabled");

    a_framer_ais:
        assert property (rx_valid_i && cfg_rdata_o.framer_ais_send
            && !cmd_i.receive_soft_reset |=> rx_data_o)
        else $error("AIS toward framer not sent");

    a_rx_free_run:
        assert property (cfg_rdata_o.receive_free_run |=> !rx_slip_o)
        else $error("Slip flagged with free-running elastic store");

    a_tx_transparent:
        assert property (tx_valid_i && cfg_rdata_o.transmit_transparent
            && !cmd_i.transmit_soft_reset |=> tx_data_o == $past(tx_data_i))
        else $error("Transmit data altered in transparent mode");

    a_tx_free_run:
        assert property (tx_valid_i && cfg_rdata_o.transmit_free_run
            && !cmd_i.transmit_soft_reset && tx_pos_ff < 9'h0C0
            |=> tx_pos_ff == $past(tx_pos_ff) + 9'h001)
        else $error("Free-running transmitter followed frame sync");

    c_los_raised:  cover property ($rose(los_o));
    c_los_cleared: cover property ($fell(los_o));
    c_t1_settled:  cover property ($rose(clock_settled_o)
                                   && cfg_rdata_o.standard_select);
    c_j1_mode:     cover property (std_mode_o == STD_J1);

endmodule

// File: line_source.sv
// Behavioural model of the PCM line that feeds received bits to the block.
module line_source (
    input  wire logic clk_i,
    input  wire logic en_i,
    input  wire logic level_i,
    output logic      valid_o,
    output logic      data_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic flip_ff = 1'h0;

    // An idle line shows a toggling pattern, so no stale bit looks steady.
    always_ff @(posedge clk_i) begin
        flip_ff <= ~flip_ff;
    end

    assign valid_o = en_i;
    assign data_o  = en_i ? level_i : flip_ff;
endmodule

// File: line_mode_config_los_bench.sv
// Self-checking testbench for the line mode, coding and LOS block.
module line_mode_config_los_bench import line_mode_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk_i, reset_i, cfg_wr_i, src_en, src_level;
    logic       tx_valid_i, tx_data_i, tx_frame_sync_i;
    logic       rx_valid_i, rx_data_i, rx_frame_sync_i;
    cfg_t       cfg_wdata_i, cfg_rdata_o, cfg;
    cmd_t       cmd_i;
    std_mode_t  std_mode_o;
    line_code_t tx_code_o, rx_code_o;
    logic       clock_settled_o, defined_mode_o, tx_valid_o, tx_data_o;
    logic       rx_valid_o, rx_data_o, rx_slip_o, los_o, los_event_o;
    int         fails = 0;
    int         n_compared = 0;
    int         cycles = 0;

    line_mode_config_los i_line_mode_config_los (
        .clk_i(clk_i), .reset_i(reset_i), .cfg_wr_i(cfg_wr_i),
        .cfg_wdata_i(cfg_wdata_i), .cmd_i(cmd_i), .tx_valid_i(tx_valid_i),
        .tx_data_i(tx_data_i), .tx_frame_sync_i(tx_frame_sync_i),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
        .rx_frame_sync_i(rx_frame_sync_i), .cfg_rdata_o(cfg_rdata_o),
        .std_mode_o(std_mode_o), .clock_settled_o(clock_settled_o),
        .tx_code_o(tx_code_o), .rx_code_o(rx_code_o),
        .defined_mode_o(defined_mode_o), .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o), .rx_valid_o(rx_valid_o),
        .rx_data_o(rx_data_o), .rx_slip_o(rx_slip_o), .los_o(los_o),
        .los_event_o(los_event_o));

    line_source i_line_source (.clk_i(clk_i), .en_i(src_en),
        .level_i(src_level), .valid_o(rx_valid_i), .data_o(rx_data_i));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'h0;
        forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    end

    // The run needs about 2500 cycles; the ceiling leaves a wide margin.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [30:0] exp,
                            input logic [30:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input cfg_t w);
        cfg_wr_i = 1'h1;
        cfg_wdata_i = w;
        tick();
        cfg_wr_i = 1'h0;
    endtask

    task automatic cmd(input logic tx, input logic rx);
        cmd_i = {tx, rx};
        tick();
        cmd_i = '0;
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk_word("cfg_rdata_o", 31'h0000_0000, cfg_rdata_o);
        chk_word("std_mode_o", 31'(STD_E1_DOUBLEFRAME), 31'(std_mode_o));
        chk_bit("clock_settled_o", 1'h1, clock_settled_o);
        chk_word("tx_code_o", 31'(CODE_AMI), 31'(tx_code_o));
        chk_bit("los_o", 1'h0, los_o);
    endtask

    task automatic t_setup();
        cfg = '0;
        cfg.compensation_disable = 1'h1;
        cfg.ais_insert_disable = 1'h1;
        cfg.receive_free_run = 1'h1;
        cfg.transmit_transparent = 1'h1;
        cfg.transmit_free_run = 1'h1;
        cfg.detection_pulse_count = 8'h0A;
        cfg.recovery_pulse_count = 8'h15;
        wr(cfg);
        chk_word("cfg_rdata_o", cfg, cfg_rdata_o);
        tick();
        chk_bit("defined_mode_o", 1'h1, defined_mode_o);
        cmd(1'h1, 1'h1);
        chk_word("cfg_rdata_o", cfg, cfg_rdata_o);
    endtask

    task automatic t_codes();
        for (int i = 0; i < 16; i++) begin
            cfg_t c;
            logic cm;
            c = cfg;
            c.transmit_code_select = i[1:0];
            c.receive_code_select = ~i[1:0];
            c.rail_mode_select = i[0];
            c.digital_interface = i[2];
            c.cmi_select = i[3];
            cm = i[2] & i[3];
            wr(c);
            tick();
            chk_word("tx_code_o", 31'({cm, i[1:0] == 2'h3}), 31'(tx_code_o));
            chk_word("rx_code_o", 31'({cm, i[1:0] == 2'h0}), 31'(rx_code_o));
        end
        wr(cfg);
    endtask

    task automatic t_tx();
        cfg_t c;
        c = cfg;
        cmd(1'h1, 1'h0);
        tx_valid_i = 1'h1;
        tx_frame_sync_i = 1'h1;
        tick();
        chk_bit("tx_valid_o", 1'h1, tx_valid_o);
        chk_bit("tx_data_o", 1'h0, tx_data_o);
        tx_valid_i = 1'h0;
        c.transmit_transparent = 1'h0;
        c.transmit_free_run = 1'h0;
        wr(c);
        tick();
        tx_valid_i = 1'h1;
        tick();
        chk_bit("tx_data_o", 1'h1, tx_data_o);
        tx_frame_sync_i = 1'h0;
        tick();
        chk_bit("tx_data_o", 1'h0, tx_data_o);
        tx_valid_i = 1'h0;
        c.transmit_free_run = 1'h1;
        wr(c);
        tick();
        cmd(1'h1, 1'h0);
        tx_valid_i = 1'h1;
        tick();
        chk_bit("tx_data_o", 1'h1, tx_data_o);
        tx_frame_sync_i = 1'h1;
        tick();
        chk_bit("tx_data_o", 1'h0, tx_data_o);
        tx_valid_i = 1'h0;
        tx_frame_sync_i = 1'h0;
        wr(cfg);
        tick();
    endtask

    task automatic t_rx();
        cfg_t c;
        for (int fr = 0; fr < 2; fr++) begin
            c = cfg;
            c.receive_free_run = fr[0];
            wr(c);
            cmd(1'h0, 1'h1);
            src_level = 1'h1;
            src_en = 1'h1;
            tick();
            rx_frame_sync_i = 1'h1;
            tick();
            chk_bit("rx_slip_o", ~fr[0], rx_slip_o);
            rx_frame_sync_i = 1'h0;
            src_en = 1'h0;
        end
        c = cfg;
        c.framer_ais_send = 1'h1;
        wr(c);
        src_level = 1'h0;
        src_en = 1'h1;
        tick();
        chk_bit("rx_valid_o", 1'h1, rx_valid_o);
        chk_bit("rx_data_o", 1'h1, rx_data_o);
        wr(cfg);
        tick();
        chk_bit("rx_data_o", 1'h0, rx_data_o);
        src_en = 1'h0;
        cmd(1'h0, 1'h1);
    endtask

    task automatic t_los();
        cfg_t c;
        c = cfg;
        c.ais_insert_disable = 1'h0;
        src_level = 1'h0;
        src_en = 1'h1;
        tick(175);
        chk_bit("los_o", 1'h0, los_o);
        tick();
        chk_bit("los_o", 1'h1, los_o);
        chk_bit("los_event_o", 1'h1, los_event_o);
        tick();
        chk_bit("los_event_o", 1'h0, los_event_o);
        chk_bit("rx_data_o", 1'h0, rx_data_o);
        wr(c);
        tick();
        chk_bit("rx_data_o", 1'h1, rx_data_o);
        wr(cfg);
        src_level = 1'h1;
        tick(21);
        chk_bit("los_o", 1'h1, los_o);
        tick();
        chk_bit("los_o", 1'h0, los_o);
        chk_bit("los_event_o", 1'h1, los_event_o);
        src_level = 1'h0;
        tick(176);
        chk_bit("los_o", 1'h1, los_o);
        cmd(1'h0, 1'h1);
        chk_bit("los_o", 1'h0, los_o);
        chk_bit("los_event_o", 1'h0, los_event_o);
        src_en = 1'h0;
    endtask

    task automatic t_std();
        cfg_t c;
        c = cfg;
        c.standard_select = 1'h1;
        wr(c);
        tick();
        chk_bit("clock_settled_o", 1'h0, clock_settled_o);
        tick(999);
        chk_bit("clock_settled_o", 1'h0, clock_settled_o);
        tick();
        chk_bit("clock_settled_o", 1'h1, clock_settled_o);
        chk_word("std_mode_o", 31'(STD_E1_DOUBLEFRAME), 31'(std_mode_o));
        tick();
        chk_word("std_mode_o", 31'(STD_T1), 31'(std_mode_o));
        c.j1_select = 1'h1;
        wr(c);
        tick();
        chk_word("std_mode_o", 31'(STD_J1), 31'(std_mode_o));
        c.standard_select = 1'h0;
        wr(c);
        tick(1002);
        chk_word("std_mode_o", 31'(STD_E1_DOUBLEFRAME), 31'(std_mode_o));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset_i = 1'h1;
        cfg_wr_i = 1'h0;
        cfg_wdata_i = '0;
        cmd_i = '0;
        tx_valid_i = 1'h0;
        tx_data_i = 1'h0;
        tx_frame_sync_i = 1'h0;
        rx_frame_sync_i = 1'h0;
        src_en = 1'h0;
        src_level = 1'h0;
        tick(20);
        reset_i = 1'h0;
        t_reset();
        t_setup();
        t_codes();
        t_tx();
        t_rx();
        t_los();
        t_std();
        end_of_test();
    end
endmodule
